// file: hw/sst_core.sv
`timescale 1ns/1ps
`default_nettype none
module sst_core (
  // Clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST_B,
  // Byte stream from host
  input  wire logic [7:0]        I_RX_DATA,
  input  wire logic              I_RX_VALID,
  output logic                   O_RX_ERROR,
  // Byte stream to host
  output logic [7:0]             O_TX_DATA,
  output logic                   O_TX_VALID,
  input  wire logic              I_TX_READY,
  // Timing sources
  input  wire logic              I_PPS,
  input  wire sst_pkg::sst_time_t I_TIME,
  input  wire logic              I_QERR_PRESENT,
  input  wire logic              I_AUTO_EN,
  // Firmware slot control
  input  wire logic              I_NEWEST_RUNNING,
  output logic                   O_RESTART,
  output logic                   O_BOOT_SLOT
);
  import sst_pkg::*;

  // ==========================================================================
  // Pulse input synchroniser
  // ==========================================================================
  logic [2:0] pps_sync;
  logic       pps_level;
  wire        pps_agree = (pps_sync[1] == pps_sync[2]);
  wire        pps_rise  = pps_agree && pps_sync[1] && !pps_level;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pps_sync  <= 3'h0;
      pps_level <= 1'b0;
    end else begin
      pps_sync  <= {pps_sync[1:0], I_PPS};
      pps_level <= pps_agree ? pps_sync[1] : pps_level;
    end
  end

  // ==========================================================================
  // Receive parser
  // ==========================================================================
  sst_rx_t     rx_st;
  sst_rx_t     next_rx_st;
  logic [7:0]  rx_id;
  logic [7:0]  rx_sub;
  logic [7:0]  rx_lenh;
  logic [15:0] rx_len;
  logic [15:0] rx_left;
  logic [7:0]  rx_mode;
  logic        rx_first;
  logic [7:0]  rx_xor;

  wire       is_dle   = (I_RX_DATA == SST_DLE);
  wire       body_end = (rx_left == 16'h0001);
  wire       ck_good  = (rx_xor == 8'h00);
  wire       frame_ok = I_RX_VALID && (rx_st == SST_R_ETX) && (I_RX_DATA == SST_ETX) && ck_good;
  wire       frame_bad = I_RX_VALID && (rx_st == SST_R_ETX) && !frame_ok;
  wire       cmd_slot = frame_ok && (rx_id == SST_ID_SLOT) && (rx_sub == SST_SUB_SLOT) &&
                        (rx_len == SST_LEN_SLOT_CMD) && (rx_mode == SST_MODE_SET);
  wire       cmd_time = frame_ok && (rx_id == SST_ID_TIME) && (rx_sub == SST_SUB_TIME) &&
                        (rx_len == SST_LEN_TIME_QRY) && (rx_mode == SST_MODE_QUERY);
  wire       dle_miss = I_RX_VALID && (rx_st == SST_R_DLE) && !is_dle;
  wire       len_zero = I_RX_VALID && (rx_st == SST_R_LENL) && ({rx_lenh, I_RX_DATA} == 16'h0000);

  always_comb begin
    next_rx_st = rx_st;
    if (I_RX_VALID) begin
      case (rx_st)
        SST_R_IDLE: next_rx_st = is_dle ? SST_R_ID : SST_R_IDLE;
        SST_R_ID:   next_rx_st = SST_R_SUB;
        SST_R_SUB:  next_rx_st = SST_R_LENH;
        SST_R_LENH: next_rx_st = SST_R_LENL;
        SST_R_LENL: next_rx_st = len_zero ? SST_R_IDLE : SST_R_BODY;
        SST_R_BODY: next_rx_st = body_end ? SST_R_DLE : SST_R_BODY;
        SST_R_DLE:  next_rx_st = is_dle ? SST_R_ETX : SST_R_IDLE;
        SST_R_ETX:  next_rx_st = SST_R_IDLE;
        default:    next_rx_st = SST_R_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_st      <= SST_R_IDLE;
      rx_id      <= 8'h00;
      rx_sub     <= 8'h00;
      rx_lenh    <= 8'h00;
      rx_len     <= 16'h0000;
      rx_left    <= 16'h0000;
      rx_mode    <= 8'h00;
      rx_first   <= 1'b0;
      rx_xor     <= 8'h00;
      O_RX_ERROR <= 1'b0;
    end else begin
      rx_st      <= next_rx_st;
      O_RX_ERROR <= frame_bad || dle_miss || len_zero;
      if (I_RX_VALID) begin
        if (rx_st == SST_R_IDLE) begin
          rx_xor <= 8'h00;
        end else if (rx_st != SST_R_DLE && rx_st != SST_R_ETX) begin
          rx_xor <= rx_xor ^ I_RX_DATA;
        end
        if (rx_st == SST_R_ID) begin
          rx_id <= I_RX_DATA;
        end
        if (rx_st == SST_R_SUB) begin
          rx_sub <= I_RX_DATA;
        end
        if (rx_st == SST_R_LENH) begin
          rx_lenh <= I_RX_DATA;
        end
        if (rx_st == SST_R_LENL) begin
          rx_len   <= {rx_lenh, I_RX_DATA};
          rx_left  <= {rx_lenh, I_RX_DATA};
          rx_first <= 1'b1;
        end
        if (rx_st == SST_R_BODY) begin
          rx_left  <= rx_left - 16'h0001;
          rx_first <= 1'b0;
          if (rx_first) begin
            rx_mode <= I_RX_DATA;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Request bookkeeping
  // ==========================================================================
  sst_kind_t   tx_kind;
  logic [4:0]  tx_idx;
  logic [7:0]  tx_ck;
  logic        slot_pend;
  logic        qry_pend;
  logic        time_pend;
  logic        restart_arm;
  logic        latest;
  sst_time_t   snap;
  logic        snap_qerr;
  logic        fifo_ready;

  wire tx_idle    = (tx_kind == SST_TX_NONE);
  wire want_time  = pps_rise && (I_AUTO_EN || qry_pend);
  wire start_slot = tx_idle && slot_pend && !restart_arm;
  wire start_time = tx_idle && !start_slot && time_pend;
  wire ck_pos_is  = (tx_kind == SST_TX_TIME) ? (tx_idx == SST_CK_TIME) : (tx_idx == SST_CK_SLOT);
  wire [4:0] ck_pos = (tx_kind == SST_TX_TIME) ? SST_CK_TIME : SST_CK_SLOT;
  wire tx_push    = !tx_idle && fifo_ready;
  wire tx_last    = tx_push && (tx_idx == 5'(ck_pos + 5'h02));

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      slot_pend <= 1'b0;
      qry_pend  <= 1'b0;
      time_pend <= 1'b0;
      latest    <= 1'b0;
    end else begin
      // New requests win over the clear in the same cycle.
      slot_pend <= cmd_slot || (slot_pend && !start_slot);
      qry_pend  <= cmd_time || (qry_pend && !pps_rise);
      time_pend <= want_time || (time_pend && !start_time);
      if (start_slot) begin
        latest <= I_NEWEST_RUNNING;
      end
    end
  end

  // The snapshot is frozen while a report is leaving so its bytes stay coherent.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      snap      <= '0;
      snap_qerr <= 1'b0;
    end else if (want_time && tx_kind != SST_TX_TIME) begin
      snap      <= I_TIME;
      snap_qerr <= I_QERR_PRESENT;
    end
  end

  // ==========================================================================
  // Frame builder
  // ==========================================================================
  function automatic logic [7:0] sst_base_byte(input sst_base_t b);
    logic [2:0] c;
    c = (b.cons > SST_CONS_MAX) ? SST_CONS_MAX : b.cons;
    return {4'h0, b.utc, c};
  endfunction : sst_base_byte

  wire [7:0]  slot_status = latest ? SST_ST_LATEST : SST_ST_RESTART;
  wire [31:0] qerr_out    = snap_qerr ? snap.qerr : 32'h0000_0000;
  wire [SST_BODY_BYTES-1:0][7:0] time_body = {
    SST_DLE, SST_ID_TIME, SST_SUB_TIME, SST_LEN_TIME_RSP, SST_MODE_RESP,
    snap.time_of_week, snap.week, snap.hour, snap.minute, snap.second,
    snap.month, snap.day, snap.year,
    sst_base_byte(snap.time_base), sst_base_byte(snap.pps_base),
    6'h00, snap.time_valid, snap.utc_valid,
    snap.utc_offset,
    qerr_out};
  wire [SST_BODY_BYTES-1:0][7:0] slot_body = {
    SST_DLE, SST_ID_SLOT, SST_SUB_SLOT, SST_LEN_SLOT_RSP, SST_MODE_RESP, slot_status,
    168'h0};
  wire [SST_BODY_BYTES-1:0][7:0] body = (tx_kind == SST_TX_TIME) ? time_body : slot_body;
  wire [7:0] body_byte = body[5'(SST_BODY_LAST - tx_idx)];
  wire [7:0] tx_byte   = ck_pos_is ? tx_ck :
                         (tx_idx == 5'(ck_pos + 5'h01)) ? SST_DLE :
                         (tx_idx == 5'(ck_pos + 5'h02)) ? SST_ETX : body_byte;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_kind <= SST_TX_NONE;
      tx_idx  <= 5'h00;
      tx_ck   <= 8'h00;
    end else if (tx_idle) begin
      tx_idx  <= 5'h00;
      tx_ck   <= 8'h00;
      tx_kind <= start_slot ? SST_TX_SLOT : (start_time ? SST_TX_TIME : SST_TX_NONE);
    end else if (tx_push) begin
      tx_idx  <= tx_idx + 5'h01;
      if (tx_idx != 5'h00 && tx_idx < ck_pos) begin
        tx_ck <= tx_ck ^ body_byte;
      end
      if (tx_last) begin
        tx_kind <= SST_TX_NONE;
      end
    end
  end

  // ==========================================================================
  // Slot switch and restart
  // ==========================================================================
  // Restart waits until the reply has fully drained so the host sees the status.
  wire restart_go = restart_arm && !O_TX_VALID;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      restart_arm <= 1'b0;
      O_RESTART   <= 1'b0;
      O_BOOT_SLOT <= 1'b0;
    end else begin
      O_RESTART <= restart_go;
      if (tx_last && tx_kind == SST_TX_SLOT && !latest) begin
        restart_arm <= 1'b1;
      end else if (restart_go) begin
        restart_arm <= 1'b0;
      end
      if (restart_go) begin
        O_BOOT_SLOT <= !O_BOOT_SLOT;
      end
    end
  end

  // ==========================================================================
  // Output buffer
  // ==========================================================================
  sst_fifo #(
    .W (SST_FIFO_W),
    .D (SST_FIFO_D)
  ) u_fifo (
    .i_clk   (I_CORE_CLK),
    .i_rst_b (I_RST_B),
    .i_data  (tx_byte),
    .i_valid (!tx_idle),
    .o_ready (fifo_ready),
    .o_data  (O_TX_DATA),
    .o_valid (O_TX_VALID),
    .i_ready (I_TX_READY)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);

  a_restart_toggle: assert property (
    O_RESTART |-> (O_BOOT_SLOT != $past(O_BOOT_SLOT)) && $past(restart_arm))
    else $error("Restart without slot change.");
  a_status_restart: assert property (
    tx_push && tx_kind == SST_TX_SLOT && tx_idx == SST_POS_STATUS && !latest
      |-> tx_byte == SST_ST_RESTART)
    else $error("Wrong restart status.");
  a_status_latest: assert property (
    tx_push && tx_kind == SST_TX_SLOT && tx_idx == SST_POS_STATUS && latest
      |-> tx_byte == SST_ST_LATEST ##1 !restart_arm)
    else $error("Wrong latest status.");
  a_length_low: assert property (
    tx_push && tx_kind == SST_TX_TIME && tx_idx == SST_POS_LENL
      |-> tx_byte == SST_LEN_TIME_RSP[7:0])
    else $error("Report length wrong.");
  a_report_after_pps: assert property (
    pps_rise && I_AUTO_EN |=> time_pend)
    else $error("Pulse edge did not request a report.");
  a_no_report_idle: assert property (
    !pps_rise && !time_pend && tx_idle && !slot_pend |=> tx_kind != SST_TX_TIME)
    else $error("Report sent without a pulse edge.");
  a_base_code: assert property (
    tx_push && tx_kind == SST_TX_TIME && (tx_idx == SST_POS_TBASE || tx_idx == SST_POS_PBASE)
      |-> tx_byte[2:0] <= SST_CONS_MAX && tx_byte[7:4] == 4'h0)
    else $error("Base byte out of range.");
  a_qerr_zero: assert property (
    tx_push && tx_kind == SST_TX_TIME && tx_idx >= SST_POS_QERR && tx_idx < SST_CK_TIME
      && !snap_qerr |-> tx_byte == 8'h00)
    else $error("Quantization error not zero.");
  a_end_sequence: assert property (
    (tx_push && ck_pos_is |=> tx_byte == SST_DLE) and
    (tx_push && tx_idx == 5'(ck_pos + 5'h01) |=> tx_byte == SST_ETX))
    else $error("Frame end sequence broken.");

  c_slot_reply: cover property (tx_last && tx_kind == SST_TX_SLOT);
  c_time_report: cover property (tx_last && tx_kind == SST_TX_TIME);
  c_restart: cover property (O_RESTART);
  c_reject: cover property (O_RX_ERROR);
endmodule : sst_core
`default_nettype wire

// file: hw/sst_pkg.sv
package sst_pkg;

  // ==========================================================================
  // Framing bytes and packet identities
  // ==========================================================================
  localparam logic [7:0]  SST_DLE        = 8'h10;
  localparam logic [7:0]  SST_ETX        = 8'h03;
  localparam logic [7:0]  SST_ID_SLOT    = 8'hA0;
  localparam logic [7:0]  SST_SUB_SLOT   = 8'h01;
  localparam logic [7:0]  SST_ID_TIME    = 8'hA1;
  localparam logic [7:0]  SST_SUB_TIME   = 8'h00;
  localparam logic [7:0]  SST_MODE_QUERY = 8'h00;
  localparam logic [7:0]  SST_MODE_SET   = 8'h01;
  localparam logic [7:0]  SST_MODE_RESP  = 8'h02;
  localparam logic [7:0]  SST_ST_RESTART = 8'h00;
  localparam logic [7:0]  SST_ST_LATEST  = 8'h01;

  // ==========================================================================
  // Length fields: mode plus data plus checksum
  // ==========================================================================
  localparam logic [15:0] SST_LEN_SLOT_CMD = 16'h000A;
  localparam logic [15:0] SST_LEN_TIME_QRY = 16'h0002;
  localparam logic [15:0] SST_LEN_SLOT_RSP = 16'h0003;
  localparam logic [15:0] SST_LEN_TIME_RSP = 16'h0018;

  // ==========================================================================
  // Byte positions within transmitted frames
  // ==========================================================================
  localparam logic [4:0]  SST_POS_LENL   = 5'h04;
  localparam logic [4:0]  SST_POS_STATUS = 5'h06;
  localparam logic [4:0]  SST_POS_TBASE  = 5'h13;
  localparam logic [4:0]  SST_POS_PBASE  = 5'h14;
  localparam logic [4:0]  SST_POS_QERR   = 5'h18;
  localparam logic [4:0]  SST_CK_SLOT    = 5'h07;
  localparam logic [4:0]  SST_CK_TIME    = 5'h1C;
  localparam logic [4:0]  SST_BODY_LAST  = 5'h1B;
  localparam int          SST_BODY_BYTES = 28;
  localparam logic [2:0]  SST_CONS_MAX   = 3'h4;

  // ==========================================================================
  // Buffering
  // ==========================================================================
  localparam int          SST_FIFO_W     = 8;
  localparam int          SST_FIFO_D     = 4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [2:0] cons;
    logic       utc;
  } sst_base_t;

  typedef struct packed {
    logic [31:0] time_of_week;
    logic [15:0] week;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [15:0] year;
    sst_base_t   time_base;
    sst_base_t   pps_base;
    logic        utc_valid;
    logic        time_valid;
    logic [15:0] utc_offset;
    logic [31:0] qerr;
  } sst_time_t;

  typedef enum logic [1:0] {SST_TX_NONE, SST_TX_SLOT, SST_TX_TIME} sst_kind_t;

  typedef enum logic [2:0] {
    SST_R_IDLE, SST_R_ID, SST_R_SUB, SST_R_LENH, SST_R_LENL, SST_R_BODY, SST_R_DLE, SST_R_ETX
  } sst_rx_t;

endpackage : sst_pkg

// file: hw/sst_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sst_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Fill side
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  // Drain side
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [0:D-1];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  wire          full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire          empty = (wptr == rptr);
  wire          push  = i_valid && !full;
  wire          pop   = i_ready && !empty;

  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= wptr + (AW+1)'(push);
      rptr <= rptr + (AW+1)'(pop);
    end
  end
endmodule : sst_fifo
`default_nettype wire

// file: testbench/sst_host.sv
`timescale 1ns/1ps
`default_nettype none
module sst_host (
  // Clock
  input  wire logic       i_clk,
  // Link to device
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  // Test control
  input  wire logic       i_stall
);
  logic [7:0] rxq[$];
  logic       ph;

  initial begin
    o_rx_data  = 8'h00;
    o_rx_valid = 1'b0;
    ph         = 1'b0;
  end

  // A stalling host takes a byte only every other cycle, so the FIFO fills.
  assign o_tx_ready = ~i_stall | ph;

  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) rxq.push_back(i_tx_data);
    ph <= #1 ~ph;
  end

  // ==========================================================================
  // Frame sender
  // ==========================================================================
  // frame build
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [7:0] ck;
    ck = 8'h00;
    for (int k = 1; k < b.size(); k++) ck ^= b[k];
    b.push_back(ck ^ {7'h00, bad});
    b.push_back(8'h10);
    b.push_back(8'h03);
    foreach (b[k]) begin
      @(posedge i_clk);
      #1;
      o_rx_data  = b[k];
      o_rx_valid = 1'b1;
    end
    @(posedge i_clk);
    #1;
    o_rx_valid = 1'b0;
    // An idle line shows no stale byte.
    o_rx_data  = ~o_rx_data;
  endtask : send
endmodule : sst_host
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sst_pkg::*;
  logic       I_CORE_CLK, I_RST_B, I_PPS, I_QERR_PRESENT, I_AUTO_EN;
  logic       I_NEWEST_RUNNING, I_TX_READY, I_RX_VALID, stall;
  logic [7:0] I_RX_DATA;
  wire  [7:0] O_TX_DATA;
  wire        O_TX_VALID, O_RX_ERROR, O_RESTART, O_BOOT_SLOT;
  sst_time_t  tm;
  logic [7:0] ex[$];
  int         errors, num_checks, restarts, rx_errs;

  sst_core i_sst_core (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_RX_DATA(I_RX_DATA),
    .I_RX_VALID(I_RX_VALID), .O_RX_ERROR(O_RX_ERROR), .O_TX_DATA(O_TX_DATA),
    .O_TX_VALID(O_TX_VALID), .I_TX_READY(I_TX_READY), .I_PPS(I_PPS), .I_TIME(tm),
    .I_QERR_PRESENT(I_QERR_PRESENT), .I_AUTO_EN(I_AUTO_EN),
    .I_NEWEST_RUNNING(I_NEWEST_RUNNING), .O_RESTART(O_RESTART),
    .O_BOOT_SLOT(O_BOOT_SLOT));

  sst_host i_sst_host (
    .i_clk(I_CORE_CLK), .o_rx_data(I_RX_DATA), .o_rx_valid(I_RX_VALID),
    .i_tx_data(O_TX_DATA), .i_tx_valid(O_TX_VALID), .o_tx_ready(I_TX_READY),
    .i_stall(stall));

  initial begin
    I_CORE_CLK = 1'b0;
    forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
  end

  always @(posedge I_CORE_CLK) begin
    if (O_RESTART === 1'b1) restarts++;
    if (O_RX_ERROR === 1'b1) rx_errs++;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic take(input int n);
    int t;
    t = 0;
    while (i_sst_host.rxq.size() < n && t < 3000) begin
      @(posedge I_CORE_CLK);
      t++;
    end
    repeat (20) @(posedge I_CORE_CLK);
    #1;
    chk(i_sst_host.rxq.size(), n);
    for (int k = 0; k < n && k < i_sst_host.rxq.size(); k++) begin
      chk(i_sst_host.rxq[k], ex[k]);
    end
    i_sst_host.rxq.delete();
  endtask : take

  task automatic pulse;
    @(posedge I_CORE_CLK);
    #1 I_PPS = 1'b1;
    repeat (8) @(posedge I_CORE_CLK);
    #1 I_PPS = 1'b0;
  endtask : pulse

  function automatic logic [7:0] base(input sst_base_t b);
    return {4'h0, b.utc, (b.cons > 3'h4) ? 3'h4 : b.cons};
  endfunction : base

  task automatic exp_time(input logic qp);
    logic [215:0] body;
    logic [7:0]   ck;
    body = {8'hA1, 8'h00, 8'h00, 8'h18, 8'h02, tm.time_of_week, tm.week,
            tm.hour, tm.minute, tm.second, tm.month, tm.day, tm.year,
            base(tm.time_base), base(tm.pps_base),
            {6'h00, tm.time_valid, tm.utc_valid}, tm.utc_offset,
            qp ? tm.qerr : 32'h0000_0000};
    ck = 8'h00;
    ex = '{8'h10};
    for (int i = 26; i >= 0; i--) begin
      ex.push_back(body[i*8+:8]);
      ck ^= body[i*8+:8];
    end
    ex.push_back(ck);
    ex.push_back(8'h10);
    ex.push_back(8'h03);
  endtask : exp_time

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // slot switch reply
  task automatic t_slot(input logic newest);
    int   rs;
    int   re;
    logic bs;
    logic [7:0] st;
    rs = restarts;
    re = rx_errs;
    bs = O_BOOT_SLOT;
    st = {7'h00, newest};
    I_NEWEST_RUNNING = newest;
    i_sst_host.send('{8'h10, 8'hA0, 8'h01, 8'h00, 8'h0A, 8'h01, 8'h00, 8'h00,
                      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    ex = '{8'h10, 8'hA0, 8'h01, 8'h00, 8'h03, 8'h02, st, 8'hA0 ^ st, 8'h10, 8'h03};
    take(10);
    chk(restarts, rs + (newest ? 0 : 1));
    chk(O_BOOT_SLOT, {31'h0, bs ^ ~newest});
    chk(rx_errs, re);
    $display("test slot switch newest=%0d done", newest);
  endtask : t_slot

  task automatic t_bad;
    int re;
    re = rx_errs;
    I_AUTO_EN = 1'b0;
    i_sst_host.send('{8'h10, 8'hA1, 8'h00, 8'h00, 8'h02, 8'h00}, 1'b1);
    repeat (4) @(posedge I_CORE_CLK);
    chk(rx_errs, re + 1);
    // A length one byte too long swallows the first end byte, so the end check fails.
    i_sst_host.send('{8'h10, 8'hA1, 8'h00, 8'h00, 8'h03, 8'h00}, 1'b0);
    repeat (4) @(posedge I_CORE_CLK);
    chk(rx_errs, re + 2);
    pulse();
    ex.delete();
    take(0);
    $display("test bad checksum done");
  endtask : t_bad

  task automatic t_query(input logic qp);
    I_AUTO_EN = 1'b0;
    I_QERR_PRESENT = qp;
    i_sst_host.send('{8'h10, 8'hA1, 8'h00, 8'h00, 8'h02, 8'h00}, 1'b0);
    repeat (30) @(posedge I_CORE_CLK);
    chk(i_sst_host.rxq.size(), 0);
    pulse();
    exp_time(qp);
    take(31);
    pulse();
    take(0);
    $display("test timing query qerr=%0d done", qp);
  endtask : t_query

  task automatic t_auto;
    I_AUTO_EN = 1'b1;
    pulse();
    exp_time(I_QERR_PRESENT);
    take(31);
    I_AUTO_EN = 1'b0;
    pulse();
    take(0);
    $display("test automatic report done");
  endtask : t_auto

  initial begin
    errors = 0;
    num_checks = 0;
    restarts = 0;
    rx_errs = 0;
    I_RST_B = 1'b0;
    I_PPS = 1'b0;
    I_QERR_PRESENT = 1'b1;
    I_AUTO_EN = 1'b0;
    I_NEWEST_RUNNING = 1'b0;
    stall = 1'b1;
    tm = '{32'h1234_5678, 16'h0901, 8'h17, 8'h3B, 8'h2A, 8'h0C, 8'h1F, 16'h07E6,
           '{3'h2, 1'b1}, '{3'h7, 1'b0}, 1'b1, 1'b0, 16'hFFEE, 32'h3F80_0000};
    repeat (2) @(posedge I_CORE_CLK);
    #1 I_RST_B = 1'b1;
    chk(O_BOOT_SLOT, 1'b0);
    t_slot(1'b0);
    stall = 1'b0;
    t_slot(1'b1);
    t_slot(1'b0);
    t_bad();
    stall = 1'b1;
    t_query(1'b1);
    tm.time_base = '{3'h4, 1'b0};
    tm.pps_base = '{3'h1, 1'b1};
    tm.utc_offset = 16'h0012;
    tm.time_valid = 1'b1;
    t_query(1'b0);
    stall = 1'b0;
    t_auto();
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge I_CORE_CLK);
    errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
